// >>> line_adapter_map.svh
`ifndef LINE_ADAPTER_MAP_SVH
`define LINE_ADAPTER_MAP_SVH

// Line table geometry
`define LT_DEPTH        64
`define LT_AW           6
`define LT_DW           8

// Line table byte offsets
`define LT_CTRL_BYTE    6'h14
`define LT_WORK0_LO     6'h17
`define LT_WORK0_HI     6'h1F
`define LT_WORK1        6'h34
`define LT_WORK2_LO     6'h38
`define LT_WORK2_HI     6'h3F
`define LT_RDADDR_BYTE  6'h37
`define LT_FW_STAT_LO   6'h0E
`define LT_FW_STAT_A    6'h10
`define LT_FW_STAT_B    6'h11

// Control byte bit positions (bit 0 is the least significant bit)
`define LCR_DTR         7
`define LCR_RTS         6
`define LCR_SEC_SYNC    5
`define LCR_SPACE_SPEED 4
`define LCR_MARK_DIRECT 3
`define LCR_LOOP        2
`define LCR_RX_ON       1
`define LCR_TX_ON       0

// Read address field of the address byte (bits 0 through 5)
`define LT_RDADDR_MSB   5
`define LT_RDADDR_LSB   0

// Reset values
`define LCR_RESET       8'h00
`define LT_RESET        8'h00

// Line levels
`define LINE_SPACE      1'b0
`define LINE_MARK       1'b1
`define RATE_NONE       4'h0

`endif

// >>> line_adapter_pkg.sv
package line_adapter_pkg;

  typedef logic [7:0] byte_type;
  typedef logic [5:0] table_addr_type;
  typedef logic [3:0] rate_type;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_HOST,
    SRC_CHAN,
    SRC_FW
  } write_source_type;

  typedef enum logic [1:0] {
    TX_DATA,
    TX_SPACE,
    TX_MARK,
    TX_IDLE
  } tx_level_type;

endpackage

// >>> line_control_adapter.sv
`timescale 1ns/1ps
`include "line_adapter_map.svh"

module line_control_adapter
  import line_adapter_pkg::*;
(
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_sys_rst,
  // Host table access
  input  wire logic           i_host_wr,
  input  wire table_addr_type i_host_addr,
  input  wire byte_type       i_host_wdata,
  input  wire logic           i_host_rd,
  output logic                o_host_rvalid,
  output byte_type            o_host_rdata,
  // Channel program table access and register load
  input  wire logic           i_chan_wr,
  input  wire table_addr_type i_chan_addr,
  input  wire byte_type       i_chan_wdata,
  input  wire logic           i_chan_rd,
  output logic                o_chan_rvalid,
  output byte_type            o_chan_rdata,
  input  wire logic           i_lcr_load,
  input  wire byte_type       i_lcr_merge,
  // Firmware status update
  input  wire logic           i_fw_wr,
  input  wire table_addr_type i_fw_addr,
  input  wire byte_type       i_fw_wdata,
  input  wire logic           i_processing,
  // Adapter type and line speed
  input  wire logic           i_sync_adapter,
  input  wire rate_type       i_line_speed,
  // Serial data paths
  input  wire logic           i_tx_serial,
  input  wire logic           i_tx_char_tick,
  input  wire logic           i_rx_line,
  output logic                o_tx_line,
  output logic                o_tx_service_req,
  output logic                o_rx_serial,
  // Data set control
  output logic                o_dtr,
  output logic                o_rts,
  output logic                o_sec_tx,
  output logic                o_new_sync,
  output logic                o_speed_sel,
  output logic                o_clk_internal,
  output rate_type            o_loop_rate,
  output logic                o_rx_enable,
  output logic                o_tx_enable,
  output byte_type            o_lcr
);

  byte_type         line_table [`LT_DEPTH];
  byte_type         lcr;
  logic             sync_meta;
  logic             sync_mode;
  logic             rx_meta;
  logic             rx_sync;
  logic             tx_loop;
  write_source_type wr_src;
  table_addr_type   wr_addr;
  byte_type         wr_data;
  tx_level_type     tx_level;
  table_addr_type   host_rd_addr;

  // Bytes only firmware may change once processing is under way
  function automatic logic fw_owned(input table_addr_type a);
    fw_owned = (a == `LT_FW_STAT_LO) || (a == `LT_FW_STAT_A) || (a == `LT_FW_STAT_B);
  endfunction

  // Free work storage bytes
  function automatic logic work_byte(input table_addr_type a);
    work_byte = ((a >= `LT_WORK0_LO) && (a <= `LT_WORK0_HI)) || (a == `LT_WORK1) ||
                ((a >= `LT_WORK2_LO) && (a <= `LT_WORK2_HI));
  endfunction

  // Software writes to firmware bytes are only allowed before processing
  function automatic logic sw_may_write(input table_addr_type a, input logic busy);
    sw_may_write = !(fw_owned(a) && busy);
  endfunction

  // Adapter type strap and receive line cross in through two flops
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_meta <= 1'b0;
      sync_mode <= 1'b0;
    end else begin
      sync_meta <= i_sync_adapter;
      sync_mode <= sync_meta;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_meta <= `LINE_MARK;
      rx_sync <= `LINE_MARK;
    end else begin
      rx_meta <= i_rx_line;
      rx_sync <= rx_meta;
    end
  end

  // Write arbitration: firmware, then channel program, then host
  always_comb begin
    wr_src  = SRC_NONE;
    wr_addr = i_host_addr;
    wr_data = i_host_wdata;
    if (i_fw_wr) begin
      wr_src  = SRC_FW;
      wr_addr = i_fw_addr;
      wr_data = i_fw_wdata;
    end else if (i_chan_wr && sw_may_write(i_chan_addr, i_processing)) begin
      wr_src  = SRC_CHAN;
      wr_addr = i_chan_addr;
      wr_data = i_chan_wdata;
    end else if (i_host_wr && sw_may_write(i_host_addr, i_processing)) begin
      wr_src  = SRC_HOST;
      wr_addr = i_host_addr;
      wr_data = i_host_wdata;
    end
  end

  // Line table storage
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `LT_DEPTH; i++) begin
        line_table[i] <= `LT_RESET;
      end
    end else if (wr_src != SRC_NONE) begin
      line_table[wr_addr] <= wr_data;
    end
  end

  // Host byte read: address from the low six bits of the address byte
  assign host_rd_addr = line_table[`LT_RDADDR_BYTE][`LT_RDADDR_MSB:`LT_RDADDR_LSB];

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_host_rvalid <= 1'b0;
      o_host_rdata  <= `LT_RESET;
    end else begin
      o_host_rvalid <= i_host_rd;
      if (i_host_rd) begin
        o_host_rdata <= line_table[host_rd_addr];
      end
    end
  end

  // Channel program read, including work and firmware bytes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_chan_rvalid <= 1'b0;
      o_chan_rdata  <= `LT_RESET;
    end else begin
      o_chan_rvalid <= i_chan_rd;
      if (i_chan_rd) begin
        o_chan_rdata <= line_table[i_chan_addr];
      end
    end
  end

  // Line control register, one per line, loaded only on request
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lcr <= `LCR_RESET;
    end else if (i_lcr_load) begin
      lcr <= line_table[`LT_CTRL_BYTE] | i_lcr_merge;
    end
  end

  assign o_lcr = lcr;

  // Data set control follows the register directly
  assign o_dtr       = lcr[`LCR_DTR];
  assign o_rts       = lcr[`LCR_RTS];
  assign o_sec_tx    = !sync_mode && lcr[`LCR_SEC_SYNC];
  assign o_new_sync  = sync_mode && lcr[`LCR_SEC_SYNC];
  assign o_speed_sel = sync_mode && lcr[`LCR_SPACE_SPEED];
  assign o_rx_enable = lcr[`LCR_RX_ON];
  assign o_tx_enable = lcr[`LCR_TX_ON];

  assign o_clk_internal = sync_mode && (lcr[`LCR_MARK_DIRECT] || lcr[`LCR_LOOP]);

  // Async loop-back bit rate comes from the line speed input
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_loop_rate <= `RATE_NONE;
    end else if (!sync_mode && lcr[`LCR_LOOP]) begin
      o_loop_rate <= i_line_speed;
    end else begin
      o_loop_rate <= `RATE_NONE;
    end
  end

  // Transmit level selection; space wins if both forcing bits are set
  always_comb begin
    tx_level = TX_DATA;
    if (!lcr[`LCR_TX_ON]) begin
      tx_level = TX_IDLE;
    end else if (!sync_mode && lcr[`LCR_SPACE_SPEED]) begin
      tx_level = TX_SPACE;
    end else if (!sync_mode && lcr[`LCR_MARK_DIRECT]) begin
      tx_level = TX_MARK;
    end
  end

  // Level actually sent, also the source of loop-back data
  always_comb begin
    unique case (tx_level)
      TX_DATA:  tx_loop = i_tx_serial;
      TX_SPACE: tx_loop = `LINE_SPACE;
      TX_MARK:  tx_loop = `LINE_MARK;
      TX_IDLE:  tx_loop = `LINE_MARK;
    endcase
  end

  // Line held at mark during loop-back so test data stays local
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_line <= `LINE_MARK;
    end else if (lcr[`LCR_LOOP]) begin
      o_tx_line <= `LINE_MARK;
    end else begin
      o_tx_line <= tx_loop;
    end
  end

  // Service requests continue at character rate even while forced
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_service_req <= 1'b0;
    end else begin
      o_tx_service_req <= i_tx_char_tick && lcr[`LCR_TX_ON];
    end
  end

  // Receive data: own line, or transmit data when looped back
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_serial <= `LINE_MARK;
    end else if (!lcr[`LCR_RX_ON]) begin
      o_rx_serial <= `LINE_MARK;
    end else if (lcr[`LCR_LOOP]) begin
      o_rx_serial <= tx_loop;
    end else begin
      o_rx_serial <= rx_sync;
    end
  end

endmodule

// >>> line_control_adapter_assertions.sv
`timescale 1ns/1ps
module line_control_adapter_checker
  import line_adapter_pkg::*;
(
  // Clock and reset
  input wire logic     i_clk,
  input wire logic     i_sys_rst,
  // Inputs
  input wire logic     i_host_rd,
  input wire logic     i_lcr_load,
  input wire logic     i_sync_adapter,
  input wire rate_type i_line_speed,
  input wire logic     i_tx_serial,
  input wire logic     i_tx_char_tick,
  // Outputs
  input wire logic     o_host_rvalid,
  input wire logic     o_tx_line,
  input wire logic     o_tx_service_req,
  input wire logic     o_dtr,
  input wire logic     o_rts,
  input wire logic     o_sec_tx,
  input wire logic     o_new_sync,
  input wire logic     o_speed_sel,
  input wire logic     o_clk_internal,
  input wire rate_type o_loop_rate,
  input wire logic     o_rx_enable,
  input wire logic     o_tx_enable,
  input wire byte_type o_lcr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [2:0] st;
  logic       asy;
  logic       syn;
  // Strap history, so mode checks skip the two-flop lag
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) st <= 3'h0;
    else st <= {st[1:0], i_sync_adapter};
  end
  assign asy = ~|{st, i_sync_adapter};
  assign syn = &{st, i_sync_adapter};
  dtr_rts_a: assert property (o_dtr == o_lcr[7] && o_rts == o_lcr[6])
    else $error("modem control differs from register");
  enables_a: assert property (o_rx_enable == o_lcr[1] && o_tx_enable == o_lcr[0])
    else $error("enables differ from register");
  lcr_hold_a: assert property (!i_lcr_load |=> $stable(o_lcr))
    else $error("register changed without load");
  force_space_a: assert property (asy && o_lcr[4] && o_lcr[0] && !o_lcr[2] |=> !o_tx_line)
    else $error("line not held at space");
  force_mark_a: assert property (asy && o_lcr[4:3] == 2'h1 && o_lcr[0] && !o_lcr[2]
    |=> o_tx_line)
    else $error("line not held at mark");
  data_pass_a: assert property (asy && o_lcr[4:3] == 2'h0 && o_lcr[0] && !o_lcr[2]
    |=> o_tx_line == $past(i_tx_serial))
    else $error("line does not carry data");
  svc_req_a: assert property (o_tx_service_req == $past(i_tx_char_tick && o_lcr[0]))
    else $error("service request wrong");
  sync_ctrl_a: assert property (syn && $stable(o_lcr) |-> o_speed_sel == o_lcr[4]
    && o_new_sync == o_lcr[5] && !o_sec_tx && o_clk_internal == (o_lcr[3] | o_lcr[2]))
    else $error("sync controls wrong");
  loop_rate_a: assert property (asy && o_lcr[2] && $stable(o_lcr) && $stable(i_line_speed)
    |-> o_loop_rate == i_line_speed)
    else $error("loop rate wrong");
  host_rd_a: assert property (i_host_rd |=> o_host_rvalid)
    else $error("no read answer");
  cover property (asy && o_lcr[4] && i_tx_char_tick);
  cover property (syn && o_lcr[3]);
  cover property (asy && o_lcr[2]);
endmodule

bind line_control_adapter line_control_adapter_checker chk (.i_clk, .i_sys_rst, .i_host_rd,
  .i_lcr_load, .i_sync_adapter, .i_line_speed, .i_tx_serial, .i_tx_char_tick, .o_host_rvalid,
  .o_tx_line, .o_tx_service_req, .o_dtr, .o_rts, .o_sec_tx, .o_new_sync, .o_speed_sel,
  .o_clk_internal, .o_loop_rate, .o_rx_enable, .o_tx_enable, .o_lcr);

// >>> line_control_adapter_test.sv
`timescale 1ns/1ps
module line_control_adapter_test
  import line_adapter_pkg::*;
;
  logic i_clk = 0, i_sys_rst = 1, i_host_wr = 0, i_host_rd = 0, i_chan_wr = 0, i_chan_rd = 0;
  logic i_lcr_load = 0, i_fw_wr = 0, i_processing = 0, i_sync_adapter = 0;
  logic i_tx_serial = 0, i_tx_char_tick = 0, i_rx_line;
  table_addr_type i_host_addr = 0, i_chan_addr = 0, i_fw_addr = 0;
  byte_type i_host_wdata = 0, i_chan_wdata = 0, i_lcr_merge = 0, i_fw_wdata = 0;
  rate_type i_line_speed = 4'h9;
  logic o_host_rvalid, o_chan_rvalid, o_tx_line, o_tx_service_req, o_rx_serial, o_dtr, o_rts;
  logic o_sec_tx, o_new_sync, o_speed_sel, o_clk_internal, o_rx_enable, o_tx_enable;
  byte_type o_host_rdata, o_chan_rdata, o_lcr;
  rate_type o_loop_rate;
  typedef struct packed {byte_type c; byte_type m; logic s; logic t;} row_type;
  row_type rows[5] = '{'{8'h81, 8'h00, 1'b0, 1'b0}, '{8'h81, 8'h00, 1'b1, 1'b1},
    '{8'h81, 8'h10, 1'b1, 1'b0}, '{8'h49, 8'h00, 1'b0, 1'b1}, '{8'h42, 8'h80, 1'b0, 1'b1}};
  int miscompares = 0;
  int n_compared = 0;
  line_control_adapter dut (.*);
  modem_data_set ds (.i_clk(i_clk), .i_line_tx(o_tx_line), .i_dtr(o_dtr), .i_rts(o_rts),
    .o_line_rx(i_rx_line));
  always #2 i_clk = ~i_clk;
  task automatic chk8(input byte_type g, input byte_type e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // s: 0 firmware, 1 channel program, 2 host
  task automatic wr(input int s, input table_addr_type a, input byte_type d);
    @(posedge i_clk);
    {i_host_wr, i_chan_wr, i_fw_wr} <= 3'b001 << s;
    {i_host_addr, i_chan_addr, i_fw_addr} <= {3{a}};
    {i_host_wdata, i_chan_wdata, i_fw_wdata} <= {3{d}};
    @(posedge i_clk);
    {i_host_wr, i_chan_wr, i_fw_wr} <= 3'b000;
  endtask
  task automatic load(input byte_type m);
    @(posedge i_clk);
    i_lcr_load <= 1;
    i_lcr_merge <= m;
    @(posedge i_clk);
    i_lcr_load <= 0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic rd(input table_addr_type a);
    @(posedge i_clk);
    {i_host_rd, i_chan_rd} <= 2'b11;
    i_chan_addr <= a;
    @(posedge i_clk);
    {i_host_rd, i_chan_rd} <= 2'b00;
    settle(0);
  endtask
  task automatic report_and_stop;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 0;
    settle(0);
    chk8(o_lcr, 8'h00);
    chk1(o_tx_line, 1'b1);
    foreach (rows[k]) begin
      wr(1, 6'h14, rows[k].c);
      i_tx_serial <= rows[k].s;
      load(rows[k].m);
      settle(2);
      chk8(o_lcr, rows[k].c | rows[k].m);
      chk1(o_tx_line, rows[k].t);
      chk8({o_dtr, o_rts, o_sec_tx, 3'h0, o_rx_enable, o_tx_enable},
        (rows[k].c | rows[k].m) & 8'hE3);
    end
    wr(1, 6'h14, 8'hE7);
    settle(2);
    chk8(o_lcr, 8'hC2);
    load(8'h00);
    settle(0);
    chk8(o_lcr, 8'hE7);
    settle(3);
    chk8({4'h0, o_loop_rate}, 8'h09);
    chk1(o_rx_serial, 1'b0);
    chk1(o_tx_line, 1'b1);
    wr(1, 6'h14, 8'h91);
    load(8'h00);
    @(posedge i_clk);
    i_tx_char_tick <= 1;
    @(posedge i_clk);
    i_tx_char_tick <= 0;
    settle(0);
    chk1(o_tx_service_req, 1'b1);
    chk1(o_tx_line, 1'b0);
    // Receiver on with the data set echoing the forced space back
    wr(1, 6'h14, 8'hD3);
    load(8'h00);
    settle(5);
    chk1(o_rx_serial, 1'b0);
    wr(2, 6'h17, 8'hA5);
    wr(2, 6'h37, 8'hD7);
    wr(1, 6'h34, 8'h5A);
    rd(6'h34);
    chk1(o_host_rvalid, 1'b1);
    chk1(o_chan_rvalid, 1'b1);
    chk8(o_host_rdata, 8'hA5);
    chk8(o_chan_rdata, 8'h5A);
    @(posedge i_clk);
    i_processing <= 1;
    wr(2, 6'h10, 8'h33);
    rd(6'h10);
    chk8(o_chan_rdata, 8'h00);
    wr(0, 6'h10, 8'h44);
    rd(6'h10);
    chk8(o_chan_rdata, 8'h44);
    @(posedge i_clk);
    i_sync_adapter <= 1;
    wr(1, 6'h14, 8'h38);
    load(8'h00);
    settle(3);
    chk8({o_new_sync, o_sec_tx, o_speed_sel, o_clk_internal, 4'h0}, 8'hB0);
    report_and_stop;
  end
endmodule

// >>> modem_data_set.sv
`timescale 1ns/1ps
module modem_data_set (
  // Clock
  input  wire logic i_clk,
  // Adapter side
  input  wire logic i_line_tx,
  input  wire logic i_dtr,
  input  wire logic i_rts,
  // Receive line
  output logic      o_line_rx = 1'b1
);
  // Echoes the line only while terminal ready and request to send are up
  always @(posedge i_clk) begin
    o_line_rx <= (i_dtr && i_rts) ? i_line_tx : 1'b1;
  end
endmodule
